/* File: src/esp_pkg.sv */
package esp_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_EV  = 16;
  localparam int NUM_IN  = 4;
  localparam int NUM_OUT = 4;
  localparam int NUM_ADC = 2;
  localparam int CW      = 16;
  localparam int SW      = 3;
  localparam int AW      = 12;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [AW-1:0] ADDR_CTRL  = 12'h000;
  localparam logic [AW-1:0] ADDR_LIMIT = 12'h004;
  localparam logic [AW-1:0] ADDR_COUNT = 12'h008;
  localparam logic [AW-1:0] ADDR_STATE = 12'h00C;
  localparam logic [AW-1:0] ADDR_OUT   = 12'h010;
  localparam logic [AW-1:0] ADDR_FLAG  = 12'h014;
  localparam logic [AW-1:0] ADDR_MASK  = 12'h018;

  // Arrays of sixteen words sit in 64-byte regions picked by address bits 11:6.
  localparam logic [5:0] REGION_CORE  = 6'h00;
  localparam logic [5:0] REGION_MATCH = 6'h04;
  localparam logic [5:0] REGION_EVCFG = 6'h05;
  localparam logic [5:0] REGION_EVACT = 6'h06;

  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_HALT_BIT  = 1;
  localparam int CTRL_BIDIR_BIT = 2;

  // ************************************************************
  // Reset values and write masks
  // ************************************************************
  localparam logic [CW-1:0] LIMIT_RST   = 16'hFFFF;
  localparam logic [CW-1:0] MATCH_RST   = 16'h0000;
  localparam logic [31:0]   EVCFG_WMASK = 32'h000F_FF3F;
  localparam logic [31:0]   EVACT_WMASK = 32'h0000_7FFF;

  // ************************************************************
  // Event configuration
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_MATCH = 2'h0,
    MODE_IO    = 2'h1,
    MODE_OR    = 2'h2,
    MODE_AND   = 2'h3
  } esp_ev_mode_type;

  typedef enum logic [1:0] {
    IO_LOW  = 2'h0,
    IO_HIGH = 2'h1,
    IO_RISE = 2'h2,
    IO_FALL = 2'h3
  } esp_io_cond_type;

  typedef struct packed {
    logic [11:0]     rsvd_hi;
    logic            state_ld;
    logic [SW-1:0]   next_state;
    logic [7:0]      state_en;
    logic [1:0]      rsvd_lo;
    esp_io_cond_type cond;
    logic [1:0]      io_sel;
    esp_ev_mode_type mode;
  } esp_evcfg_type;

  typedef struct packed {
    logic [16:0]        rsvd;
    logic               halt;
    logic               stop;
    logic               start;
    logic               limit;
    logic               dma;
    logic [NUM_ADC-1:0] adc;
    logic [NUM_OUT-1:0] out_clr;
    logic [NUM_OUT-1:0] out_set;
  } esp_evact_type;

endpackage

/* File: src/esp_sync3.sv */
`timescale 1ns/1ns
module esp_sync3 #(
  parameter int W = 4
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= i_async;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // A bit is accepted only when the two settled stages agree.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_level <= '0;
    end else begin
      for (int b = 0; b < W; b++) begin
        if (ff2[b] == ff3[b]) begin
          o_level[b] <= ff3[b];
        end
      end
    end
  end

endmodule

/* File: src/esp_event_unit.sv */
`timescale 1ns/1ns
module esp_event_unit (
  input  wire logic                       i_live,
  input  wire logic [esp_pkg::CW-1:0]     i_count,
  input  wire logic [esp_pkg::CW-1:0]     i_match,
  input  wire logic [esp_pkg::NUM_IN-1:0] i_io,
  input  wire logic [esp_pkg::NUM_IN-1:0] i_io_prev,
  input  wire esp_pkg::esp_evcfg_type     i_cfg,
  input  wire logic [esp_pkg::SW-1:0]     i_state,
  output logic                            o_fire
);

  logic hit_match;
  logic hit_io;
  logic cur;
  logic prv;
  logic cond_ok;

  always_comb begin
    hit_match = i_live && (i_count == i_match);
    cur = i_io[i_cfg.io_sel];
    prv = i_io_prev[i_cfg.io_sel];
    case (i_cfg.cond)
      esp_pkg::IO_LOW:  hit_io = ~cur;
      esp_pkg::IO_HIGH: hit_io = cur;
      esp_pkg::IO_RISE: hit_io = cur & ~prv;
      esp_pkg::IO_FALL: hit_io = ~cur & prv;
      default:          hit_io = 1'b0;
    endcase
    case (i_cfg.mode)
      esp_pkg::MODE_MATCH: cond_ok = hit_match;
      esp_pkg::MODE_IO:    cond_ok = hit_io;
      esp_pkg::MODE_OR:    cond_ok = hit_match | hit_io;
      esp_pkg::MODE_AND:   cond_ok = hit_match & hit_io;
      default:             cond_ok = 1'b0;
    endcase
    o_fire = cond_ok & i_cfg.state_en[i_state];
  end

endmodule

/* File: src/esp_timer.sv */
`timescale 1ns/1ns
module esp_timer (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_resetn,
  input  wire logic [esp_pkg::AW-1:0]      i_paddr,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic [esp_pkg::NUM_IN-1:0]  i_sig,
  output logic      [esp_pkg::NUM_OUT-1:0] o_pwm,
  output logic      [esp_pkg::NUM_ADC-1:0] o_adc_trig,
  output logic                             o_dma_req,
  output logic                             o_irq
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic                        ctr_run;
  logic                        ctr_halt;
  logic                        bidir;
  logic                        cnt_down;
  logic [esp_pkg::CW-1:0]      count;
  logic [esp_pkg::CW-1:0]      limit;
  logic [esp_pkg::SW-1:0]      state;
  logic [esp_pkg::SW-1:0]      next_state;
  logic [esp_pkg::NUM_EV-1:0]  ev_flag;
  logic [esp_pkg::NUM_EV-1:0]  ev_mask;
  logic [esp_pkg::NUM_EV-1:0]  fire;
  logic [esp_pkg::NUM_IN-1:0]  io_lvl;
  logic [esp_pkg::NUM_IN-1:0]  io_prev;
  logic [esp_pkg::CW-1:0]      match_act [esp_pkg::NUM_EV];
  logic [esp_pkg::CW-1:0]      match_shd [esp_pkg::NUM_EV];
  esp_pkg::esp_evcfg_type      ev_cfg    [esp_pkg::NUM_EV];
  esp_pkg::esp_evact_type      ev_act    [esp_pkg::NUM_EV];
  esp_pkg::esp_evact_type      act_sum;
  logic                        ctr_live;
  logic                        at_top;
  logic                        at_bottom;
  logic                        reload;
  logic                        wr_en;
  logic                        setup;
  logic [31:0]                 rd_data;
  logic                        rd_err;

  function automatic logic [5:0] region(input logic [esp_pkg::AW-1:0] a);
    return a[11:6];
  endfunction

  function automatic logic [3:0] word_idx(input logic [esp_pkg::AW-1:0] a);
    return a[5:2];
  endfunction

  function automatic logic core_hit(input logic [esp_pkg::AW-1:0] a, input logic [esp_pkg::AW-1:0] r);
    return a == r;
  endfunction

  // ************************************************************
  // Inputs
  // ************************************************************
  esp_sync3 #(
    .W (esp_pkg::NUM_IN)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_sig),
    .o_level   (io_lvl)
  );

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      io_prev <= '0;
    end else begin
      io_prev <= io_lvl;
    end
  end

  // ************************************************************
  // Events
  // ************************************************************
  assign ctr_live = ctr_run & ~ctr_halt;

  for (genvar g = 0; g < esp_pkg::NUM_EV; g++) begin : g_ev
    esp_event_unit u_ev (
      .i_live    (ctr_live),
      .i_count   (count),
      .i_match   (match_act[g]),
      .i_io      (io_lvl),
      .i_io_prev (io_prev),
      .i_cfg     (ev_cfg[g]),
      .i_state   (state),
      .o_fire    (fire[g])
    );
  end

  // Actions of every fired event merge; the highest event wins a state jump.
  always_comb begin
    act_sum = '0;
    next_state = state;
    for (int i = 0; i < esp_pkg::NUM_EV; i++) begin
      if (fire[i]) begin
        act_sum = esp_pkg::esp_evact_type'(act_sum | ev_act[i]);
        if (ev_cfg[i].state_ld) begin
          next_state = ev_cfg[i].next_state;
        end
      end
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  assign at_top = count == limit;
  assign at_bottom = count == '0;
  assign reload = act_sum.limit | (ctr_live & (bidir ? ((~cnt_down & at_top) | (cnt_down & at_bottom))
                                                     : at_top));

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= '0;
      cnt_down <= 1'b0;
    end else if (act_sum.limit) begin
      count <= '0;
      cnt_down <= 1'b0;
    end else if (wr_en && core_hit(i_paddr, esp_pkg::ADDR_COUNT)) begin
      count <= i_pwdata[esp_pkg::CW-1:0];
    end else if (ctr_live) begin
      if (!bidir) begin
        count <= at_top ? '0 : count + 1'b1;
        cnt_down <= 1'b0;
      end else if (!cnt_down) begin
        count <= at_top ? count - 1'b1 : count + 1'b1;
        cnt_down <= at_top;
      end else begin
        count <= at_bottom ? count + 1'b1 : count - 1'b1;
        cnt_down <= ~at_bottom;
      end
    end
  end

  // Event commands override a software write in the same cycle.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctr_run <= 1'b0;
      ctr_halt <= 1'b0;
      bidir <= 1'b0;
    end else begin
      if (wr_en && core_hit(i_paddr, esp_pkg::ADDR_CTRL)) begin
        ctr_run <= i_pwdata[esp_pkg::CTRL_RUN_BIT];
        ctr_halt <= i_pwdata[esp_pkg::CTRL_HALT_BIT];
        bidir <= i_pwdata[esp_pkg::CTRL_BIDIR_BIT];
      end
      if (act_sum.stop) begin
        ctr_run <= 1'b0;
      end else if (act_sum.start) begin
        ctr_run <= 1'b1;
      end
      if (act_sum.halt) begin
        ctr_halt <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      limit <= esp_pkg::LIMIT_RST;
    end else if (wr_en && core_hit(i_paddr, esp_pkg::ADDR_LIMIT)) begin
      limit <= i_pwdata[esp_pkg::CW-1:0];
    end
  end

  // ************************************************************
  // Match registers
  // ************************************************************
  // Software reaches only the shadows; the active set changes all at once.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < esp_pkg::NUM_EV; i++) begin
        match_act[i] <= esp_pkg::MATCH_RST;
        match_shd[i] <= esp_pkg::MATCH_RST;
      end
    end else begin
      if (wr_en && region(i_paddr) == esp_pkg::REGION_MATCH) begin
        match_shd[word_idx(i_paddr)] <= i_pwdata[esp_pkg::CW-1:0];
      end
      if (reload) begin
        for (int i = 0; i < esp_pkg::NUM_EV; i++) begin
          match_act[i] <= match_shd[i];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < esp_pkg::NUM_EV; i++) begin
        ev_cfg[i] <= '0;
        ev_act[i] <= '0;
      end
    end else if (wr_en) begin
      if (region(i_paddr) == esp_pkg::REGION_EVCFG) begin
        ev_cfg[word_idx(i_paddr)] <= esp_pkg::esp_evcfg_type'(i_pwdata & esp_pkg::EVCFG_WMASK);
      end
      if (region(i_paddr) == esp_pkg::REGION_EVACT) begin
        ev_act[word_idx(i_paddr)] <= esp_pkg::esp_evact_type'(i_pwdata & esp_pkg::EVACT_WMASK);
      end
    end
  end

  // ************************************************************
  // State, outputs and triggers
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= '0;
    end else if (next_state != state || !(wr_en && core_hit(i_paddr, esp_pkg::ADDR_STATE))) begin
      state <= next_state;
    end else begin
      state <= i_pwdata[esp_pkg::SW-1:0];
    end
  end

  // Clear beats set on the same pin so a conflict leaves the switch off.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pwm <= '0;
    end else if (wr_en && core_hit(i_paddr, esp_pkg::ADDR_OUT) && fire == '0) begin
      o_pwm <= i_pwdata[esp_pkg::NUM_OUT-1:0];
    end else begin
      o_pwm <= (o_pwm | act_sum.out_set) & ~act_sum.out_clr;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_adc_trig <= '0;
      o_dma_req <= 1'b0;
    end else begin
      o_adc_trig <= act_sum.adc;
      o_dma_req <= act_sum.dma;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_flag <= '0;
    end else if (wr_en && core_hit(i_paddr, esp_pkg::ADDR_FLAG)) begin
      ev_flag <= (ev_flag & ~i_pwdata[esp_pkg::NUM_EV-1:0]) | fire;
    end else begin
      ev_flag <= ev_flag | fire;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_mask <= '0;
    end else if (wr_en && core_hit(i_paddr, esp_pkg::ADDR_MASK)) begin
      ev_mask <= i_pwdata[esp_pkg::NUM_EV-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ev_flag & ev_mask);
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // No wait state: ready rises in the first access cycle.
  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & i_pwrite & o_pready & ~o_pslverr;

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    case (region(i_paddr))
      esp_pkg::REGION_CORE: begin
        case (i_paddr)
          esp_pkg::ADDR_CTRL:  rd_data = {29'h0, bidir, ctr_halt, ctr_run};
          esp_pkg::ADDR_LIMIT: rd_data = {16'h0, limit};
          esp_pkg::ADDR_COUNT: rd_data = {16'h0, count};
          esp_pkg::ADDR_STATE: rd_data = {29'h0, state};
          esp_pkg::ADDR_OUT:   rd_data = {28'h0, o_pwm};
          esp_pkg::ADDR_FLAG:  rd_data = {16'h0, ev_flag};
          esp_pkg::ADDR_MASK:  rd_data = {16'h0, ev_mask};
          default:             rd_err = 1'b1;
        endcase
      end
      esp_pkg::REGION_MATCH: rd_data = {16'h0, match_shd[word_idx(i_paddr)]};
      esp_pkg::REGION_EVCFG: rd_data = ev_cfg[word_idx(i_paddr)];
      esp_pkg::REGION_EVACT: rd_data = ev_act[word_idx(i_paddr)];
      default:               rd_err = 1'b1;
    endcase
    if (i_paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
      rd_data = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & rd_err;
      if (setup && !i_pwrite) begin
        o_prdata <= rd_data;
      end else if (setup) begin
        o_prdata <= '0;
      end
    end
  end

endmodule

/* File: verif/esp_inverter_model.sv */
`timescale 1ns/1ns
module esp_inverter_model (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_resetn,
  input  wire logic [esp_pkg::NUM_OUT-1:0] i_pwm,
  input  wire logic [esp_pkg::NUM_ADC-1:0] i_adc_trig,
  output logic      [esp_pkg::NUM_IN-1:0]  o_sig,
  output logic      [15:0]                 o_samples
);
  // ************************************************************
  // Phase sense and sampling
  // ************************************************************
  // The legs follow the gate commands one cycle late, so the sensed phase levels lag the drive.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sig <= '0;
    end else begin
      o_sig <= i_pwm[esp_pkg::NUM_IN-1:0];
    end
  end

  // Each cycle with a pulse on either trigger takes one current sample.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_samples <= 16'h0000;
    end else if (|i_adc_trig) begin
      o_samples <= o_samples + 16'h0001;
    end
  end
endmodule

/* File: verif/esp_timer_props.sv */
`timescale 1ns/1ns
module esp_timer_props (
  input wire logic                        i_sys_clk,
  input wire logic                        i_resetn,
  input wire logic [esp_pkg::AW-1:0]      i_paddr,
  input wire logic                        i_psel,
  input wire logic                        i_penable,
  input wire logic                        i_pwrite,
  input wire logic [31:0]                 i_pwdata,
  input wire logic [31:0]                 o_prdata,
  input wire logic                        o_pready,
  input wire logic                        o_pslverr,
  input wire logic [esp_pkg::NUM_IN-1:0]  i_sig,
  input wire logic [esp_pkg::NUM_OUT-1:0] o_pwm,
  input wire logic [esp_pkg::NUM_ADC-1:0] o_adc_trig,
  input wire logic                        o_dma_req,
  input wire logic                        o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  logic setup_c;
  assign setup_c = i_psel & ~i_penable;

  sequence apb_setup_s;
    setup_c;
  endsequence
  sequence apb_access_s;
    i_psel && i_penable && o_pready;
  endsequence

  setup_answer_a: assert property (apb_setup_s |=> apb_access_s) else $error("no answer after setup");
  ready_single_a: assert property (o_pready |=> !o_pready) else $error("ready held too long");
  ready_access_a: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
  err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  unaligned_err_a: assert property (setup_c && i_paddr[1:0] != 2'h0 |=> o_pslverr) else $error("unaligned accepted");
  core_ok_a: assert property (setup_c && i_paddr == esp_pkg::ADDR_CTRL |=> !o_pslverr) else $error("control refused");
  err_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000) else $error("error read not 0");
  rdata_hold_a: assert property (!setup_c |=> $stable(o_prdata)) else $error("read data moved");
  reset_quiet_a: assert property ($rose(i_resetn) |-> o_pwm == '0 && o_adc_trig == '0 && !o_dma_req && !o_irq)
    else $error("outputs active after reset");
endmodule

bind esp_timer esp_timer_props u_props (
  .i_sys_clk  (i_sys_clk),
  .i_resetn   (i_resetn),
  .i_paddr    (i_paddr),
  .i_psel     (i_psel),
  .i_penable  (i_penable),
  .i_pwrite   (i_pwrite),
  .i_pwdata   (i_pwdata),
  .o_prdata   (o_prdata),
  .o_pready   (o_pready),
  .o_pslverr  (o_pslverr),
  .i_sig      (i_sig),
  .o_pwm      (o_pwm),
  .o_adc_trig (o_adc_trig),
  .o_dma_req  (o_dma_req),
  .o_irq      (o_irq)
);

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } esp_row_type;

  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sig;
  logic [3:0]  pwm;
  logic [1:0]  adc_trig;
  logic        dma_req;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        er;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          hits;
  esp_row_type rows [8];

  always #25 sys_clk = ~sys_clk;

  esp_timer DUT (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sig(sig), .o_pwm(pwm), .o_adc_trig(adc_trig), .o_dma_req(dma_req), .o_irq(irq)
  );

  esp_inverter_model u_inv (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_pwm(pwm), .i_adc_trig(adc_trig), .o_sig(sig), .o_samples()
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The request is held until the edge that samples ready, and released only after it.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts cycles up to the next pulse of one trigger and pulses of the other meanwhile.
  task automatic gap(input int k, input int exp, input int exp_other);
    int c = 0;
    int o = 0;
    do begin
      @(posedge sys_clk);
      c++;
      if (adc_trig[1-k] === 1'b1) o++;
    end while (adc_trig[k] !== 1'b1);
    if (exp >= 0) check(c, exp, "trigger spacing");
    if (exp_other >= 0) check(o, exp_other, "other trigger count");
  endtask

  task give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ************************************************************
  // Hang guard
  // ************************************************************
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    rows[0] = '{esp_pkg::ADDR_LIMIT, 32'h0000_0027, 32'h0000_0027, 1'b0};
    rows[1] = '{esp_pkg::ADDR_MASK, 32'h0000_0003, 32'h0000_0003, 1'b0};
    rows[2] = '{12'h100, 32'h0000_0005, 32'h0000_0005, 1'b0};
    rows[3] = '{12'h104, 32'h0000_000C, 32'h0000_000C, 1'b0};
    rows[4] = '{12'h140, 32'hFFFF_FFFF, esp_pkg::EVCFG_WMASK, 1'b0};
    rows[5] = '{12'h180, 32'hFFFF_FFFF, esp_pkg::EVACT_WMASK, 1'b0};
    rows[6] = '{12'h0FC, 32'h1234_5678, 32'h0000_0000, 1'b1};
    rows[7] = '{12'h002, 32'h1234_5678, 32'h0000_0000, 1'b1};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(esp_pkg::ADDR_LIMIT, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_FFFF, "limit after reset");
    apb(esp_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "control after reset");
    foreach (rows[i]) begin
      apb(rows[i].addr, 1'b1, rows[i].wdata);
      apb(rows[i].addr, 1'b0, 32'h0000_0000);
      check(rd, rows[i].exp, "read back");
      check({31'h0, er}, {31'h0, rows[i].err}, "slave error");
    end
    // Event 0 sets pin 0 at count 5, event 1 clears it at count 12, period 40.
    apb(12'h140, 1'b1, 32'h0000_0100);
    apb(12'h180, 1'b1, 32'h0000_0501);
    apb(12'h144, 1'b1, 32'h0000_0300);
    apb(12'h184, 1'b1, 32'h0000_0210);
    apb(esp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    // Both active matches still hold their reset value, so both events fire at count 0.
    gap(0, 2, 1);
    check({31'h0, pwm[0]}, 32'h0000_0000, "clear beats set at count 0");
    gap(0, 45, 0);
    gap(0, 40, 1);
    check({31'h0, pwm[0]}, 32'h0000_0001, "pin set at rising match");
    check({31'h0, dma_req}, 32'h0000_0001, "transfer request with trigger");
    gap(1, 7, 0);
    check({31'h0, pwm[0]}, 32'h0000_0000, "pin cleared at falling match");
    apb(12'h100, 1'b1, 32'h0000_0002);
    apb(12'h104, 1'b1, 32'h0000_001E);
    gap(0, -1, 0);
    gap(1, 28, 0);
    // Event 0 now moves to state 1, where only event 1 stays enabled.
    apb(12'h140, 1'b1, 32'h0009_0100);
    hits = 0;
    repeat (120) begin
      @(posedge sys_clk);
      if (adc_trig[0] === 1'b1) hits++;
    end
    check(hits, 1, "event fires once then gated");
    apb(esp_pkg::ADDR_STATE, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001, "state moved by event");
    apb(12'h184, 1'b1, 32'h0000_2210);
    gap(1, -1, 0);
    apb(esp_pkg::ADDR_COUNT, 1'b0, 32'h0000_0000);
    rd2 = rd;
    apb(esp_pkg::ADDR_COUNT, 1'b0, 32'h0000_0000);
    check(rd, rd2, "counter stopped by event");
    apb(esp_pkg::ADDR_FLAG, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0003, "event flags");
    check({31'h0, irq}, 32'h0000_0001, "interrupt raised");
    apb(esp_pkg::ADDR_MASK, 1'b1, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0000_0000, "interrupt masked");
    apb(esp_pkg::ADDR_FLAG, 1'b1, 32'h0000_0003);
    apb(esp_pkg::ADDR_MASK, 1'b1, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0000_0000, "interrupt cleared");
    apb(esp_pkg::ADDR_FLAG, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "flags cleared");
    // Event 2 fires once on the rise that the inverter feeds back from pin 0.
    apb(12'h148, 1'b1, 32'h0000_0221);
    apb(12'h188, 1'b1, 32'h0000_0100);
    apb(esp_pkg::ADDR_OUT, 1'b1, 32'h0000_0001);
    hits = 0;
    repeat (20) begin
      @(posedge sys_clk);
      if (adc_trig[0] === 1'b1) hits++;
    end
    check(hits, 1, "input rise event fires once");
    // Up-down from count 31 with limit 39; the top turn loads match 20 for event 1.
    apb(12'h184, 1'b1, 32'h0000_0200);
    apb(12'h104, 1'b1, 32'h0000_0014);
    apb(esp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0005);
    gap(1, 29, 0);
    gap(1, 40, 0);
    gap(1, 38, 0);
    // A second reset in mid-run must quiet every output and restore the defaults.
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({24'h0, irq, dma_req, adc_trig, pwm}, 32'h0000_0000, "outputs in reset");
    resetn <= 1'b1;
    apb(esp_pkg::ADDR_LIMIT, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_FFFF, "limit after second reset");
    apb(esp_pkg::ADDR_STATE, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "state after second reset");
    give_verdict();
  end
endmodule
